// file: rdc_defines.svh
// Purpose: constants of the direct command unit
// Assumes: byte-wide command codes, AXI4-Lite word registers
// Notes: offsets are byte addresses
`ifndef RDC_DEFINES_SVH
`define RDC_DEFINES_SVH

// =====================================================================
// Command codes
`define RDC_CMD_CAL_DRV 8'hd8
`define RDC_CMD_MEAS_PH 8'hd9
`define RDC_CMD_CLR_RSSI 8'hda
`define RDC_CMD_CLR_FIFO 8'hdb
`define RDC_CMD_TRANSP 8'hdc
`define RDC_CMD_GPT 8'he0
`define RDC_CMD_WUT 8'he1
`define RDC_CMD_MRT 8'he2
`define RDC_CMD_SPACE_B 8'hfb
`define RDC_CMD_TEST 8'hfc
`define RDC_CMD_DEF0 8'hc0
`define RDC_CMD_DEF1 8'hc1
`define RDC_CMD_STOP0 8'hc2
`define RDC_CMD_STOP1 8'hc3

// =====================================================================
// Register offsets
`define RDC_OFF_CMD 12'h000
`define RDC_OFF_OPCTL 12'h004
`define RDC_OFF_STAT 12'h008
`define RDC_OFF_IRQ 12'h00c
`define RDC_OFF_DONE 12'h010

// =====================================================================
// Operation control fields
`define RDC_OP_EN 0
`define RDC_OP_RX_EN 1
`define RDC_OP_TX_EN 2
`define RDC_OP_WU 3
`define RDC_OP_FD_EN 4
`define RDC_OP_PD 5
`define RDC_OP_AR_LSB 6
`define RDC_OP_AR_MSB 7
`define RDC_OPCTL_RST 8'h00
`define RDC_AR_MODE1 2'b01

// =====================================================================
// Status fields
`define RDC_ST_BUSY 0
`define RDC_ST_TRANSP 1
`define RDC_ST_SPACE_B 2
`define RDC_ST_TEST 3
`define RDC_ST_FIELD 4
`define RDC_ST_GPT 5
`define RDC_ST_WUT 6
`define RDC_ST_MRT 7
`define RDC_ST_SQL 8
`define RDC_ST_CA 9
`define RDC_ST_FOFF 10
`define RDC_ST_RXSEEN 11
`define RDC_ST_TEMP 12
`define RDC_ST_CAL 13
`define RDC_ST_OSC 14
`define RDC_ST_TRX 15
`define RDC_ST_FDT 16

// Irq status bits
`define RDC_IRQ_PHASE 0
`define RDC_IRQ_W 8

// =====================================================================
// Timing: phase measurement 2 us at 200 MHz
`define RDC_MEAS_NS 2000
`define RDC_CLK_NS 5
`define RDC_MEAS_CYC (`RDC_MEAS_NS / `RDC_CLK_NS)
`define RDC_CNT_W 10

`endif

// file: rdc_pkg.sv
// Purpose: types of the direct command unit
// Assumes: nothing beyond the defines header
// Notes: shared by all three design files
package rdc_pkg;
  typedef enum logic [1:0] {
    RDC_IDLE = 2'b00,
    RDC_EXEC = 2'b01,
    RDC_MEAS = 2'b10
  } rdc_state_t;

  typedef logic [7:0] rdc_code_t;
endpackage

// file: rdc_cmd_if.sv
// Purpose: carries a decoded command from decoder to executor
// Assumes: one clock, codes valid for one cycle
// Notes: decoder drives, executor consumes
`timescale 1ns/1ps
interface rdc_cmd_if;
  logic valid;
  rdc_pkg::rdc_code_t code;
  logic accept;
  logic irq_done;

  modport src (output valid, output code, output accept, output irq_done);
  modport dst (input valid, input code, input accept, input irq_done);
endinterface

// file: rdc_gate.sv
// Purpose: checks a command code against operation-control bits
// Assumes: code presented for one cycle with valid
// Notes: pure decode, registered by the top
`timescale 1ns/1ps
`include "rdc_defines.svh"
module rdc_gate (
  input wire logic i_valid,
  input wire rdc_pkg::rdc_code_t i_code,
  input wire logic [7:0] i_opctl,
  rdc_cmd_if.src cmd
);
  import rdc_pkg::*;

  wire en = i_opctl[`RDC_OP_EN];
  wire wu = i_opctl[`RDC_OP_WU];
  wire pd = i_opctl[`RDC_OP_PD];
  wire is_def = (i_code == `RDC_CMD_DEF0) || (i_code == `RDC_CMD_DEF1);
  wire is_stop = (i_code == `RDC_CMD_STOP0) || (i_code == `RDC_CMD_STOP1);
  wire is_en_cmd = (i_code == `RDC_CMD_CAL_DRV) ||
                   (i_code == `RDC_CMD_CLR_RSSI) ||
                   (i_code == `RDC_CMD_CLR_FIFO) ||
                   (i_code == `RDC_CMD_TRANSP) ||
                   (i_code == `RDC_CMD_GPT) ||
                   (i_code == `RDC_CMD_MRT);
  wire is_all = (i_code == `RDC_CMD_SPACE_B) ||
                (i_code == `RDC_CMD_TEST);
  wire is_ph = (i_code == `RDC_CMD_MEAS_PH);
  wire is_wut = (i_code == `RDC_CMD_WUT);
  // Phase measure runs in any mode, even powered down
  wire ok = is_def || (is_stop && en) || (is_en_cmd && en) ||
            is_all || is_ph || (is_wut && !wu);

  assign cmd.valid = i_valid;
  assign cmd.code = i_code;
  assign cmd.accept = i_valid && ok;
  assign cmd.irq_done = is_ph;
  wire unused_pd = pd;
endmodule

// file: rdc_top.sv
// Purpose: direct command decoder and executor with AXI4-Lite registers
// Assumes: single 200 MHz clock, synchronous active-high reset
// Notes: analog effects appear as status flags and strobes
`timescale 1ns/1ps
`include "rdc_defines.svh"
module rdc_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_rx_event,
  input wire logic i_ca_event,
  input wire logic i_foff_event,
  output logic o_irq,
  output logic o_fifo_clear,
  output logic o_rssi_restart,
  output logic o_cal_start,
  output logic o_osc_en,
  output logic o_transparent,
  output logic o_space_b,
  output logic o_test_access
);
  import rdc_pkg::*;

  // ===================================================================
  // Pin synchronisers for outside events
  logic [2:0] ev_meta_reg;
  logic [2:0] ev_sync_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ev_meta_reg <= 3'h0;
      ev_sync_reg <= 3'h0;
    end else begin
      ev_meta_reg <= {i_foff_event, i_ca_event, i_rx_event};
      ev_sync_reg <= ev_meta_reg;
    end
  end
  wire rx_seen_ev = ev_sync_reg[0];
  wire ca_ev = ev_sync_reg[1];
  wire foff_ev = ev_sync_reg[2];

  // ===================================================================
  // AXI4-Lite write channel
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic awready_reg;
  logic wready_reg;
  // Only a real handshake takes a channel; avoids a repeated write
  wire aw_take = i_awvalid && awready_reg && !bvalid_reg;
  wire w_take = i_wvalid && wready_reg && !bvalid_reg;
  wire aw_have = aw_hold_reg || aw_take;
  wire w_have = w_hold_reg || w_take;
  wire [11:0] wr_addr = aw_hold_reg ? awaddr_reg : i_awaddr;
  wire [31:0] wr_data = w_hold_reg ? wdata_reg : i_wdata;
  wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : i_wstrb;
  wire wr_fire = aw_have && w_have && !bvalid_reg;
  wire wr_cmd = wr_fire && (wr_addr == `RDC_OFF_CMD) && wr_strb[0];
  wire wr_op = wr_fire && (wr_addr == `RDC_OFF_OPCTL) && wr_strb[0];
  wire wr_irq = wr_fire && (wr_addr == `RDC_OFF_IRQ) && wr_strb[0];
  wire wr_ok = (wr_addr == `RDC_OFF_CMD) || (wr_addr == `RDC_OFF_OPCTL) ||
               (wr_addr == `RDC_OFF_IRQ);
  logic [1:0] bresp_reg;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? 2'b00 : 2'b10;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  // Ready is registered so the outputs stay flop driven
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      awready_reg <= !aw_hold_reg && !aw_take && !wr_fire && !bvalid_reg;
      wready_reg <= !w_hold_reg && !w_take && !wr_fire && !bvalid_reg;
    end
  end

  // ===================================================================
  // Command decode and execution state
  logic [7:0] opctl_reg;
  logic [7:0] opctl_next;
  rdc_cmd_if cmd ();
  rdc_gate u_gate (
    .i_valid(wr_cmd),
    .i_code(wr_data[7:0]),
    .i_opctl(opctl_reg),
    .cmd(cmd)
  );

  wire acc = cmd.accept;
  wire is_def = acc && ((cmd.code == `RDC_CMD_DEF0) ||
                        (cmd.code == `RDC_CMD_DEF1));
  wire is_stop = acc && ((cmd.code == `RDC_CMD_STOP0) ||
                         (cmd.code == `RDC_CMD_STOP1));
  // Restore-defaults always runs stop-all first
  wire stop_all = is_stop || is_def;
  wire c_cal = acc && (cmd.code == `RDC_CMD_CAL_DRV);
  wire c_ph = acc && (cmd.code == `RDC_CMD_MEAS_PH);
  wire c_rssi = acc && (cmd.code == `RDC_CMD_CLR_RSSI);
  wire c_fifo = acc && (cmd.code == `RDC_CMD_CLR_FIFO);
  wire c_tr = acc && (cmd.code == `RDC_CMD_TRANSP);
  wire c_gpt = acc && (cmd.code == `RDC_CMD_GPT);
  wire c_wut = acc && (cmd.code == `RDC_CMD_WUT);
  wire c_mrt = acc && (cmd.code == `RDC_CMD_MRT);
  wire c_spb = acc && (cmd.code == `RDC_CMD_SPACE_B);
  wire c_tst = acc && (cmd.code == `RDC_CMD_TEST);
  wire ar_mode1 = opctl_reg[`RDC_OP_AR_MSB:`RDC_OP_AR_LSB] == `RDC_AR_MODE1;

  // Operation control survives stop-all; only defaults reset it
  always_comb begin
    opctl_next = opctl_reg;
    if (wr_op) begin
      opctl_next = wr_data[7:0];
    end
    if (is_def) begin
      opctl_next = `RDC_OPCTL_RST;
    end
  end

  rdc_state_t state_reg;
  rdc_state_t state_next;
  logic [`RDC_CNT_W-1:0] cnt_reg;
  wire meas_done = (state_reg == RDC_MEAS) &&
                   (cnt_reg == `RDC_CNT_W'(`RDC_MEAS_CYC - 1));
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RDC_IDLE: begin
        if (c_ph) begin
          state_next = RDC_MEAS;
        end
      end
      RDC_MEAS: begin
        if (meas_done) begin
          state_next = RDC_IDLE;
        end
      end
      default: begin
        state_next = RDC_IDLE;
      end
    endcase
    if (stop_all) begin
      state_next = RDC_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= RDC_IDLE;
      cnt_reg <= '0;
      opctl_reg <= `RDC_OPCTL_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next == RDC_MEAS && state_reg == RDC_MEAS) ?
                 cnt_reg + `RDC_CNT_W'(1) : '0;
      opctl_reg <= opctl_next;
    end
  end

  // ===================================================================
  // Activity flags
  logic [16:0] st_reg;
  logic irq_st_reg;
  logic irq_reg;
  wire field_on = st_reg[`RDC_ST_FIELD];
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || is_def) begin
      // Defaults drop calibration, mode and access state
      st_reg <= 17'h0_0000;
    end else begin
      st_reg[`RDC_ST_BUSY] <= state_next == RDC_MEAS;
      if (c_tr) st_reg[`RDC_ST_TRANSP] <= 1'b1;
      if (c_spb) st_reg[`RDC_ST_SPACE_B] <= 1'b1;
      if (c_tst) st_reg[`RDC_ST_TEST] <= 1'b1;
      // Field stays on after stop-all, even if field-off pends
      if (ca_ev && !stop_all) st_reg[`RDC_ST_FIELD] <= 1'b1;
      if (foff_ev && !stop_all) st_reg[`RDC_ST_FIELD] <= 1'b0;
      st_reg[`RDC_ST_GPT] <= stop_all ? 1'b0 :
                             (st_reg[`RDC_ST_GPT] | c_gpt);
      st_reg[`RDC_ST_WUT] <= stop_all ? 1'b0 :
                             (st_reg[`RDC_ST_WUT] | c_wut);
      st_reg[`RDC_ST_MRT] <= stop_all ? 1'b0 :
                             (st_reg[`RDC_ST_MRT] | c_mrt);
      st_reg[`RDC_ST_SQL] <= stop_all ? 1'b0 :
                             (st_reg[`RDC_ST_SQL] | c_mrt);
      st_reg[`RDC_ST_CA] <= stop_all ? 1'b0 :
                            (st_reg[`RDC_ST_CA] | ca_ev);
      st_reg[`RDC_ST_FOFF] <= stop_all ? 1'b0 :
                              (st_reg[`RDC_ST_FOFF] | foff_ev);
      if (stop_all && ar_mode1) begin
        st_reg[`RDC_ST_RXSEEN] <= 1'b0;
      end else if (rx_seen_ev) begin
        st_reg[`RDC_ST_RXSEEN] <= 1'b1;
      end
      st_reg[`RDC_ST_TEMP] <= stop_all ? 1'b0 :
                              (st_reg[`RDC_ST_TEMP] | rx_seen_ev);
      if (c_cal) st_reg[`RDC_ST_CAL] <= 1'b1;
      // Oscillator forced only while a powered-down measure runs
      st_reg[`RDC_ST_OSC] <= (state_next == RDC_MEAS) &&
                             opctl_reg[`RDC_OP_PD];
      st_reg[`RDC_ST_TRX] <= stop_all ? 1'b0 :
                             (st_reg[`RDC_ST_TRX] | rx_seen_ev);
      st_reg[`RDC_ST_FDT] <= stop_all ? 1'b0 :
                             (st_reg[`RDC_ST_FDT] | rx_seen_ev);
    end
  end

  // ===================================================================
  // Completion interrupt: only phase measure raises one
  wire irq_clr = wr_irq && wr_data[`RDC_IRQ_PHASE];
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || stop_all) begin
      irq_st_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_st_reg <= meas_done || (irq_st_reg && !irq_clr);
      irq_reg <= meas_done || (irq_st_reg && !irq_clr);
    end
  end

  // ===================================================================
  // One-cycle strobes to the analog side
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_fifo_clear <= 1'b0;
      o_rssi_restart <= 1'b0;
      o_cal_start <= 1'b0;
    end else begin
      o_fifo_clear <= c_fifo || stop_all;
      o_rssi_restart <= c_rssi;
      o_cal_start <= c_cal;
    end
  end

  // ===================================================================
  // AXI4-Lite read channel
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire ar_take = i_arvalid && arready_reg;
  wire rd_ok = (i_araddr == `RDC_OFF_OPCTL) || (i_araddr == `RDC_OFF_STAT) ||
               (i_araddr == `RDC_OFF_IRQ) || (i_araddr == `RDC_OFF_CMD);
  wire [31:0] rd_mux = (i_araddr == `RDC_OFF_OPCTL) ? {24'h00_0000, opctl_reg} :
                       (i_araddr == `RDC_OFF_STAT) ? {15'h0000, st_reg} :
                       (i_araddr == `RDC_OFF_IRQ) ? {31'h0000_0000, irq_st_reg} :
                       32'h0000_0000;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_ok ? 2'b00 : 2'b10;
    end else if (rvalid_reg) begin
      if (i_rready) rvalid_reg <= 1'b0;
    end else begin
      arready_reg <= 1'b1;
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_irq = irq_reg;
  assign o_osc_en = st_reg[`RDC_ST_OSC];
  assign o_transparent = st_reg[`RDC_ST_TRANSP];
  assign o_space_b = st_reg[`RDC_ST_SPACE_B];
  assign o_test_access = st_reg[`RDC_ST_TEST];
  wire unused_ok = field_on | cmd.irq_done | cmd.valid;
endmodule

// file: rdc_fe_model.sv
// Purpose: front-end event source on the far side of the unit
// Assumes: each fire bit is a one-cycle request from the bench
// Notes: bit 0 reception, bit 1 collision avoidance, bit 2 field-off
`timescale 1ns/1ps
module rdc_fe_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [2:0] i_fire,
  output logic [2:0] o_event
);
  logic [2:0] ev_reg;
  logic [3:0] cnt_reg;

  // Events are levels held for some cycles, as the analog side gives them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ev_reg <= 3'h0;
      cnt_reg <= 4'h0;
    end else if (|i_fire) begin
      ev_reg <= i_fire;
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      ev_reg <= 3'h0;
    end
  end

  assign o_event = ev_reg;
endmodule

// file: rdc_top_asserts.sv
// Purpose: port-level checks of the direct command unit
// Assumes: one clock, synchronous active-high reset
// Notes: command data stays on the write bus after it is taken
`timescale 1ns/1ps
`include "rdc_defines.svh"
module rdc_top_asserts (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_wdata,
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_fifo_clear,
  input wire logic o_rssi_restart,
  input wire logic o_cal_start,
  input wire logic o_osc_en,
  input wire logic o_transparent,
  input wire logic o_space_b,
  input wire logic o_test_access
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ==================================================================
  // Command strobes and levels
  property p_cal_pulse; o_cal_start |=> !o_cal_start; endproperty
  a_cal_pulse: assert property (p_cal_pulse)
    else $error("calibration strobe longer than one cycle");
  property p_cal_cause;
    $rose(o_cal_start) |-> $past(i_wdata[7:0]) == `RDC_CMD_CAL_DRV;
  endproperty
  a_cal_cause: assert property (p_cal_cause)
    else $error("calibration started by another code");
  property p_rssi_pulse; o_rssi_restart |=> !o_rssi_restart; endproperty
  a_rssi_pulse: assert property (p_rssi_pulse)
    else $error("signal strength restart longer than one cycle");
  property p_transp_cause;
    $rose(o_transparent) |-> $past(i_wdata[7:0]) == `RDC_CMD_TRANSP;
  endproperty
  a_transp_cause: assert property (p_transp_cause)
    else $error("transparent mode entered by another code");
  property p_space_cause;
    $rose(o_space_b) |-> $past(i_wdata[7:0]) == `RDC_CMD_SPACE_B;
  endproperty
  a_space_cause: assert property (p_space_cause)
    else $error("secondary space opened by another code");
  property p_test_cause;
    $rose(o_test_access) |-> $past(i_wdata[7:0]) == `RDC_CMD_TEST;
  endproperty
  a_test_cause: assert property (p_test_cause)
    else $error("test access opened by another code");

  // ==================================================================
  // Phase measurement; only the interrupt check excludes an abort by stop-all
  property p_osc_hold; $rose(o_osc_en) |-> o_osc_en [*8]; endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("oscillator dropped early in a measurement");
  property p_osc_irq;
    $fell(o_osc_en) && !o_fifo_clear && !$past(o_fifo_clear)
      |-> ##[0:2] o_irq;
  endproperty
  a_osc_irq: assert property (p_osc_irq)
    else $error("measurement ended without interrupt");

  // ==================================================================
  // Bus answers stand until taken
  property p_b_stand;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand)
    else $error("write response withdrawn before taken");
  property p_r_stand;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand)
    else $error("read data withdrawn before taken");
endmodule

bind rdc_top rdc_top_asserts i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_wdata(i_wdata), .i_bready(i_bready), .i_rready(i_rready),
  .o_bvalid(o_bvalid), .o_bresp(o_bresp), .o_rvalid(o_rvalid),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_fifo_clear(o_fifo_clear),
  .o_rssi_restart(o_rssi_restart), .o_cal_start(o_cal_start),
  .o_osc_en(o_osc_en), .o_transparent(o_transparent),
  .o_space_b(o_space_b), .o_test_access(o_test_access));

// file: reader_direct_command_unit_test.sv
// Purpose: command-level test of the direct command unit
// Assumes: register answers come within the bench wait bound
// Notes: front-end events come from the partner model
`timescale 1ns/1ps
`include "rdc_defines.svh"
module reader_direct_command_unit_test;
  logic i_clk = 0, i_sys_rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, o_rdata;
  logic [1:0] resp, o_bresp, o_rresp;
  logic [2:0] fire = 0, ev;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_osc;
  logic o_fifo_clear, o_rssi, o_cal, o_transp, o_space_b, o_test;
  int n_errors = 0, checks_done = 0, n_fc = 0, n_rs = 0, n_cs = 0, k;
  logic [7:0] codes [8] = '{8'hd8, 8'hda, 8'hdb, 8'hdc, 8'he0, 8'he1,
    8'he2, 8'h55};
  logic [7:0] defs [2] = '{`RDC_CMD_DEF0, `RDC_CMD_DEF1};

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    n_fc <= n_fc + (o_fifo_clear === 1'b1);
    n_rs <= n_rs + (o_rssi === 1'b1);
    n_cs <= n_cs + (o_cal === 1'b1);
  end

  rdc_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(o_awready), .i_wdata(wd),
    .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bry),
    .i_araddr(ara), .i_arvalid(arv), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(rry), .i_rx_event(ev[0]), .i_ca_event(ev[1]),
    .i_foff_event(ev[2]), .o_irq(o_irq), .o_fifo_clear(o_fifo_clear),
    .o_rssi_restart(o_rssi), .o_cal_start(o_cal), .o_osc_en(o_osc),
    .o_transparent(o_transp), .o_space_b(o_space_b),
    .o_test_access(o_test));
  rdc_fe_model i_fe (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fire(fire),
    .o_event(ev));

  // ==================================================================
  // Reporting
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tmo();
    n_errors++;
    $display("MISMATCH wait expected answer seen none");
    results();
  endtask

  // ==================================================================
  // Register bus; ready flags sampled mid-cycle, as flops hold them
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge i_clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    for (k = 0; k < 200; k++) begin
      @(negedge i_clk);
      ah = awv & o_awready;
      wh = wv & o_wready;
      bh = bry & o_bvalid;
      resp = o_bresp;
      @(posedge i_clk);
      if (ah) awv <= 0;
      if (wh) wv <= 0;
      if (bh) break;
    end
    bry <= 0;
    if (k == 200) tmo();
  endtask

  task automatic rd(input logic [11:0] a);
    logic ah, rh;
    @(posedge i_clk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    for (k = 0; k < 200; k++) begin
      @(negedge i_clk);
      ah = arv & o_arready;
      rh = rry & o_rvalid;
      rdat = o_rdata;
      resp = o_rresp;
      @(posedge i_clk);
      if (ah) arv <= 0;
      if (rh) break;
    end
    rry <= 0;
    if (k == 200) tmo();
  endtask

  task automatic cmd(input logic [7:0] c);
    wr(`RDC_OFF_CMD, {24'h00_0000, c});
    repeat (3) @(posedge i_clk);
  endtask

  task automatic pulse_fire(input logic [2:0] f);
    fire <= f;
    @(posedge i_clk);
    fire <= 3'h0;
    repeat (16) @(posedge i_clk);
  endtask

  // ==================================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 0;
    repeat (2) @(posedge i_clk);
    rd(`RDC_OFF_OPCTL);
    check("opctl_reset", rdat, 32'h0000_0000);
    rd(`RDC_OFF_DONE);
    check("unmapped_resp", resp, 32'h0000_0002);
    wr(`RDC_OFF_DONE, 32'h0000_00d8);
    check("wr_unmapped", resp, 32'h0000_0002);
    // Nothing enabled: enable-gated codes must drop, wake-up timer still runs
    foreach (codes[i]) cmd(codes[i]);
    check("cal_gated", n_cs, 0);
    check("rssi_gated", n_rs, 0);
    check("transp_gated", o_transp, 0);
    rd(`RDC_OFF_STAT);
    check("timers_gated", rdat[7:5], 3'h2);
    cmd(`RDC_CMD_SPACE_B);
    cmd(`RDC_CMD_TEST);
    check("space_b_any", o_space_b, 1);
    check("test_any", o_test, 1);
    i_sys_rst <= 1;
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 0;
    repeat (2) @(posedge i_clk);
    wr(`RDC_OFF_OPCTL, 32'h0000_0009);
    check("wr_okay", resp, 32'h0000_0000);
    cmd(`RDC_CMD_WUT);
    rd(`RDC_OFF_STAT);
    check("wut_in_wake", rdat[`RDC_ST_WUT], 0);
    wr(`RDC_OFF_OPCTL, 32'h0000_0041);
    foreach (codes[i]) cmd(codes[i]);
    check("cal_once", n_cs, 1);
    check("rssi_once", n_rs, 1);
    check("fifo_once", n_fc, 1);
    check("transp_on", o_transp, 1);
    check("no_irq", o_irq, 0);
    rd(`RDC_OFF_STAT);
    check("timers_run", rdat[7:5], 3'h7);
    check("squelch", rdat[`RDC_ST_SQL], 1);
    pulse_fire(3'b011);
    wr(`RDC_OFF_OPCTL, 32'h0000_0061);
    cmd(`RDC_CMD_MEAS_PH);
    check("osc_on", o_osc, 1);
    wait_irq();
    repeat (3) @(posedge i_clk);
    check("osc_off", o_osc, 0);
    rd(`RDC_OFF_IRQ);
    check("phase_irq", rdat[`RDC_IRQ_PHASE], 1);
    rd(`RDC_OFF_STAT);
    check("rx_seen", rdat[`RDC_ST_RXSEEN], 1);
    cmd(`RDC_CMD_STOP0);
    check("irq_line", o_irq, 0);
    check("fifo_stop", n_fc, 2);
    check("transp_kept", o_transp, 1);
    rd(`RDC_OFF_IRQ);
    check("irq_stat", rdat[`RDC_IRQ_PHASE], 0);
    rd(`RDC_OFF_OPCTL);
    check("opctl_kept", rdat, 32'h0000_0061);
    rd(`RDC_OFF_STAT);
    check("timers_stop", rdat[7:5], 3'h0);
    check("fdt_stop", rdat[`RDC_ST_FDT], 0);
    check("trx_stop", rdat[`RDC_ST_TRX], 0);
    check("ca_stop", rdat[`RDC_ST_CA], 0);
    check("rx_forgot", rdat[`RDC_ST_RXSEEN], 0);
    check("field_kept", rdat[`RDC_ST_FIELD], 1);
    wr(`RDC_OFF_OPCTL, 32'h0000_0001);
    pulse_fire(3'b101);
    cmd(`RDC_CMD_STOP1);
    rd(`RDC_OFF_STAT);
    check("foff_cancel", rdat[`RDC_ST_FOFF], 0);
    check("rx_kept", rdat[`RDC_ST_RXSEEN], 1);
    foreach (defs[i]) begin
      cmd(`RDC_CMD_SPACE_B);
      cmd(defs[i]);
      check("def_space_b", o_space_b, 0);
      check("def_no_irq", o_irq, 0);
      rd(`RDC_OFF_OPCTL);
      check("def_opctl", rdat, 32'h0000_0000);
      rd(`RDC_OFF_STAT);
      check("def_cal", rdat[`RDC_ST_CAL], 0);
    end
    check("def_transp", o_transp, 0);
    results();
  end

  task automatic wait_irq();
    for (k = 0; k < 1000 && o_irq !== 1'b1; k++) @(negedge i_clk);
    if (k == 1000) tmo();
  endtask
endmodule
